// File: include/xid_pkg.sv
// package: encodings, field positions, widths and constants for the extended decoder
package xid_pkg;
	// widths of the core's address and pointer arithmetic
	localparam int ADDR_W = 12;
	localparam int PC_W   = 21;
	localparam int INSN_W = 16;

	// opcodes of the extended set: first-word prefixes (upper eight bits), second-word nibble, whole call word
	localparam logic [7:0] OP_PTR_ADD  = 8'h_E8;
	localparam logic [7:0] OP_PTR_SUB  = 8'h_E9;
	localparam logic [7:0] OP_PUSH_LIT = 8'h_EA;
	localparam logic [7:0] OP_MOVE_IDX = 8'h_EB;
	localparam logic [3:0] OP_SECOND   = 4'h_F;
	localparam logic [15:0] OP_CALL_WORK = 16'h_0014;

	// field positions inside instruction words
	localparam int SEL_HI  = 7;
	localparam int SEL_LO  = 6;
	localparam int LIT6_HI = 5;
	localparam int MV_KIND = 7;
	localparam int OFS7_HI = 6;
	localparam int ACC_BIT = 8;
	localparam int DST_BIT = 9;

	// selector value that picks the software stack pointer with return
	localparam logic [1:0] SEL_STACK_RET = 2'h_3;
	localparam logic [1:0] SEL_STACK     = 2'h_2;

	// indexed window top for low access-bank operands
	localparam logic [7:0] IDX_LIMIT = 8'h_5F;
	// upper part of the access bank lives in the top bank
	localparam logic [3:0] TOP_BANK  = 4'h_F;

	// indirect-register window: operand registers at the top of the space
	localparam logic [11:0] INDIRECT_LO = 12'h_FDB;
	localparam logic [11:0] INDIRECT_HI = 12'h_FEF;
	localparam logic [7:0]  READ_ZERO   = 8'h_00;

	// instruction length step of the program counter
	localparam logic [20:0] PC_STEP = 21'h_00_0002;
	localparam logic [11:0] ONE_12  = 12'h_001;

	// execution sequencer states
	typedef enum logic [1:0] {
		XID_RUN  = 2'b00, // decode a new word
		XID_NOP  = 2'b01, // forced no-operation cycle
		XID_MOVE = 2'b10  // second word of an indexed move
	} xid_state_t;
endpackage : xid_pkg

// File: test/testbench.sv
// self-checking testbench for the extended instruction decoder
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic        core_clk, reset_n, xinstCfg, insnValid;
	logic [15:0] insnWord;
	logic [20:0] progCounter, stackTop, pcTarget, pushAddr;
	logic [7:0]  workReg, pcLatchHigh, rdData, memData;
	logic [4:0]  pcLatchUpper;
	logic [3:0]  bankSel;
	logic [11:0] ptr0, ptr1, ptr2, memAddr, operandAddr, rdAddr;
	logic        pcLoad, stackPush, stackPop, memWrite, operandToW, busy;
	int          failures, checked;
	logic [11:0] expPtr [3]; // pointer values worked out by the bench

	xid_decode_core u_dut (.core_clk(core_clk), .reset_n(reset_n), .xinstCfg(xinstCfg),
		.insnValid(insnValid), .insnWord(insnWord), .progCounter(progCounter),
		.workReg(workReg), .pcLatchHigh(pcLatchHigh), .pcLatchUpper(pcLatchUpper),
		.stackTop(stackTop), .bankSel(bankSel), .rdData(rdData), .ptr0(ptr0), .ptr1(ptr1),
		.ptr2(ptr2), .pcLoad(pcLoad), .pcTarget(pcTarget), .stackPush(stackPush),
		.pushAddr(pushAddr), .stackPop(stackPop), .memWrite(memWrite), .memAddr(memAddr),
		.memData(memData), .operandAddr(operandAddr), .operandToW(operandToW), .busy(busy));

	xid_data_mem u_mem (.core_clk(core_clk), .wrEn(memWrite), .wrAddr(memAddr),
		.wrData(memData), .rdAddr(rdAddr), .rdData(rdData));

	// free-running 20 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// compare and count; prints on mismatch only
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// one word driven after the next edge and taken at the edge after that, outputs sampled just after the edge that takes it
	task automatic issue(input logic [15:0] w);
		@(posedge core_clk);
		insnValid <= 1'b1;
		insnWord  <= w;
		@(posedge core_clk);
		insnValid <= 1'b0;
		#1;
	endtask : issue

	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ 8'h5A;
	endfunction : pat

	// add and subtract on all three pointers, ending in a wrap below zero
	task automatic t_ptr();
		logic [11:0] cur [3];
		for (int s = 0; s < 3; s++) begin
			issue({8'hE8, 2'(s), 6'h3F});
			issue({8'hE9, 2'(s), 6'h20});
			issue({8'hE9, 2'(s), 6'h3F});
			cur[0] = ptr0;
			cur[1] = ptr1;
			cur[2] = ptr2;
			expPtr[s] = 12'hFE0;
			chk(32'(cur[s]), 32'(expPtr[s]));
		end
	endtask : t_ptr

	// indexed to absolute move; first source hits the indirect window
	// second word follows the first on the very next edge
	task automatic t_move_abs(input logic [6:0] z, input logic [11:0] dst, input logic [7:0] e);
		rdAddr <= expPtr[2] + 12'(z);
		@(posedge core_clk);
		insnValid <= 1'b1;
		insnWord  <= {8'hEB, 1'b0, z};
		@(posedge core_clk);
		insnWord  <= {4'hF, dst};
		#1;
		chk(32'(busy), 32'h1);
		@(posedge core_clk);
		insnValid <= 1'b0;
		#1;
		chk(32'({memWrite, memAddr, memData}), 32'({1'b1, dst, e}));
	endtask : t_move_abs

	// indexed to indexed move: both addresses relative to the stack pointer
	task automatic t_move_idx();
		issue({8'hEB, 1'b1, 7'h30});
		rdAddr <= 12'h010;
		issue({4'hF, 5'h00, 7'h7F});
		chk(32'({memWrite, memAddr, memData}), 32'({1'b1, 12'h05F, pat(12'h010)}));
	endtask : t_move_idx

	// push literal: write at the pointer, then step it down
	task automatic t_push(input logic [7:0] k);
		issue({8'hEA, k});
		chk(32'({memWrite, memAddr, memData}), 32'({1'b1, expPtr[2], k}));
		expPtr[2] = expPtr[2] - 12'h001;
		chk(32'(ptr2), 32'(expPtr[2]));
	endtask : t_push

	// selector three on add or subtract: adjust stack pointer, return, one nop
	task automatic t_return(input logic [7:0] op, input logic [5:0] k, input logic [11:0] e);
		stackTop <= 21'h1ABCD;
		issue({op, 2'h3, k});
		chk(32'({pcLoad, stackPop, busy, pcTarget}), 32'({3'b111, 21'h1ABCD}));
		chk(32'(ptr2), 32'(e));
		@(posedge core_clk);
		#1;
		chk(32'({pcLoad, stackPop, busy}), 32'h0);
		expPtr[2] = e;
	endtask : t_return

	// call through the working register
	task automatic t_call();
		progCounter  <= 21'h001000;
		workReg      <= 8'h06;
		pcLatchHigh  <= 8'h10;
		pcLatchUpper <= 5'h03;
		issue(16'h0014);
		chk(32'({stackPush, pushAddr}), 32'({1'b1, 21'h001002}));
		chk(32'({pcLoad, busy, pcTarget}), 32'({2'b11, 21'h031006}));
		@(posedge core_clk);
		#1;
		chk(32'({stackPush, pcLoad, busy}), 32'h0);
	endtask : t_call

	// standard add-W-to-file word with destination and access bits; checks resolved address
	task automatic t_op(input logic d, input logic a, input logic [7:0] f, input logic [11:0] e);
		issue({6'b001001, d, a, f});
		chk(32'({operandToW, operandAddr}), 32'({~d, e}));
	endtask : t_op

	task automatic complete_run();
		$display("checks made %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	// watchdog: the whole sequence needs under a hundred cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		failures++;
		complete_run();
	end

	// main sequence
	initial begin
		reset_n = 1'b0;
		xinstCfg = 1'b1;
		insnValid = 1'b0;
		insnWord = 16'h0000;
		progCounter = 21'h0;
		stackTop = 21'h0;
		workReg = 8'h00;
		pcLatchHigh = 8'h00;
		pcLatchUpper = 5'h00;
		bankSel = 4'h3;
		rdAddr = 12'h000;
		failures = 0;
		checked = 0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		#1;
		chk(32'({ptr0, ptr1}), 32'h0);
		chk(32'({ptr2, pcLoad, stackPush, stackPop, memWrite, busy}), 32'h0);
		t_ptr();
		t_move_abs(7'h00, 12'h123, 8'h00);
		t_move_abs(7'h7F, 12'h000, pat(12'h05F));
		t_move_idx();
		t_push(8'hA5);
		t_push(8'h00);
		t_return(8'hE8, 6'h03, 12'hFE1);
		t_return(8'hE9, 6'h01, 12'hFE0);
		t_call();
		t_op(1'b0, 1'b0, 8'h05, 12'hFE5);
		t_op(1'b1, 1'b0, 8'h5F, 12'h03F);
		t_op(1'b0, 1'b0, 8'h60, 12'hF60);
		t_op(1'b1, 1'b1, 8'h05, 12'h305);
		issue({8'hE8, 2'h2, 6'h20});
		t_op(1'b1, 1'b0, 8'h05, 12'h005);
		issue({8'hE8, 2'h2, 6'h10});
		@(posedge core_clk);
		xinstCfg <= 1'b0;
		issue({8'hE8, 2'h2, 6'h3F});
		chk(32'(ptr2), 32'h010);
		issue({8'hEA, 8'h77});
		chk(32'(memWrite), 32'h0);
		t_op(1'b0, 1'b0, 8'h05, 12'h005);
		complete_run();
	end
endmodule : testbench

// File: test/xid_data_mem.sv
// data memory model on the far side of the decoder: fixed fill pattern, write port, async read
module xid_data_mem (
	input  wire logic        core_clk, // instruction clock
	input  wire logic        wrEn,     // write pulse from the decoder
	input  wire logic [11:0] wrAddr,   // write address
	input  wire logic [7:0]  wrData,   // write value
	input  wire logic [11:0] rdAddr,   // read address chosen by the bench
	output logic      [7:0]  rdData    // read value, combinational
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] store [4096]; // whole 4096-byte data space, every address answers

	// fill with an address-derived pattern so that a wrong source address shows up
	initial begin
		for (int i = 0; i < 4096; i++) begin
			store[i] = 8'(i) ^ 8'h5A;
		end
	end

	// writes land on the rising edge, like the real array
	always @(posedge core_clk) begin
		if (wrEn) begin
			store[wrAddr] <= wrData;
		end
	end

	// read is combinational so the second move word sees the source value at once
	assign rdData = store[rdAddr];
endmodule : xid_data_mem

// File: verilog/xid_addr_map.sv
// operand address resolver: indexed literal offset versus access/bank mapping
module xid_addr_map (
	input  wire logic        xinstOn,    // extension enable
	input  wire logic [7:0]  operand,    // file operand of the instruction
	input  wire logic        accessBit,  // access bit of the instruction
	input  wire logic [3:0]  bankSel,    // bank select register
	input  wire logic [11:0] stackPtr,   // software stack pointer
	output logic      [11:0] dataAddr    // resolved data address
);
	// purely combinational; the caller registers the result
	always_comb begin
		if (xinstOn && !accessBit && operand <= xid_pkg::IDX_LIMIT) begin
			dataAddr = stackPtr + {4'h_0, operand};
		end else if (!accessBit) begin
			// low part of the access bank (up to IDX_LIMIT) is bank zero, high part the top bank
			dataAddr = (operand <= xid_pkg::IDX_LIMIT) ? {4'h_0, operand}
				: {xid_pkg::TOP_BANK, operand};
		end else begin
			dataAddr = {bankSel, operand};
		end
	end
endmodule : xid_addr_map

// File: verilog/xid_decode_core.sv
// extended instruction decode and execute unit of the 8-bit core
//
// Design decisions made here: strobed register access and the register offsets.
module xid_decode_core (
	input  wire logic        core_clk,     // instruction clock
	input  wire logic        reset_n,      // asynchronous, active low
	input  wire logic        xinstCfg,     // nonvolatile extension enable
	input  wire logic        insnValid,    // an instruction word is offered
	input  wire logic [15:0] insnWord,     // fetched instruction word
	input  wire logic [20:0] progCounter,  // address of the offered word
	input  wire logic [7:0]  workReg,      // working register
	input  wire logic [7:0]  pcLatchHigh,  // program counter latch high
	input  wire logic [4:0]  pcLatchUpper, // program counter latch upper
	input  wire logic [20:0] stackTop,     // top of the return stack
	input  wire logic [3:0]  bankSel,      // bank select register
	input  wire logic [7:0]  rdData,       // data memory read value
	output logic      [11:0] ptr0,         // file select pointer 0
	output logic      [11:0] ptr1,         // file select pointer 1
	output logic      [11:0] ptr2,         // software stack pointer
	output logic             pcLoad,       // load program counter (pulse)
	output logic      [20:0] pcTarget,     // new program counter value
	output logic             stackPush,    // push on return stack (pulse)
	output logic      [20:0] pushAddr,     // value pushed
	output logic             stackPop,     // pop return stack (pulse)
	output logic             memWrite,     // data memory write (pulse)
	output logic      [11:0] memAddr,      // data memory write address
	output logic      [7:0]  memData,      // data memory write value
	output logic      [11:0] operandAddr,  // resolved address of standard ops
	output logic             operandToW,   // standard result goes to W
	output logic             busy          // forced second cycle in progress
);
	// state of the sequencer and its next values
	xid_pkg::xid_state_t state, next_state;
	logic [11:0] next_ptr0, next_ptr1, next_ptr2;
	logic        next_pcLoad, next_stackPush, next_stackPop, next_memWrite;
	logic [20:0] next_pcTarget, next_pushAddr;
	logic [11:0] next_memAddr, next_operandAddr;
	logic [7:0]  next_memData;
	logic        next_operandToW, next_busy;
	logic [11:0] srcHeld, next_srcHeld;   // move source held across words
	logic        idxDest, next_idxDest;   // 1 = second word is an offset

	// config gate: no extended word starts while it is low; only the second word of a move begun earlier still writes
	logic        extOn;
	assign extOn = xinstCfg;

	// decoded fields of the offered word
	logic [7:0]  opHi;
	logic [1:0]  sel;
	logic [5:0]  lit6;
	logic [6:0]  ofs7;
	assign opHi = insnWord[15:8];
	assign sel  = insnWord[xid_pkg::SEL_HI:xid_pkg::SEL_LO];
	assign lit6 = insnWord[xid_pkg::LIT6_HI:0];
	assign ofs7 = insnWord[xid_pkg::OFS7_HI:0];

	// pick one pointer by selector
	function automatic logic [11:0] pickPtr(input logic [1:0] s, input logic [11:0] a,
		input logic [11:0] b, input logic [11:0] c);
		case (s)
			2'h_0:   pickPtr = a;
			2'h_1:   pickPtr = b;
			default: pickPtr = c;
		endcase
	endfunction : pickPtr

	// stack-relative address, wraps modulo the data space
	function automatic logic [11:0] stackRel(input logic [11:0] p, input logic [6:0] o);
		stackRel = p + {5'h_00, o};
	endfunction : stackRel

	// true when the address is an indirect-access register
	function automatic logic isIndirect(input logic [11:0] a);
		isIndirect = (a >= xid_pkg::INDIRECT_LO) && (a <= xid_pkg::INDIRECT_HI);
	endfunction : isIndirect

	// pointer arithmetic unit shared by add and subtract
	logic [11:0] aluOut;
	xid_ptr_alu u_alu (
		.ptrIn  (pickPtr(sel, ptr0, ptr1, ptr2)),
		.lit    (lit6),
		.doSub  (opHi == xid_pkg::OP_PTR_SUB),
		.ptrOut (aluOut)
	);

	// operand resolver for standard byte and bit instructions
	logic [11:0] mappedAddr;
	xid_addr_map u_map (
		.xinstOn   (extOn),
		.operand   (insnWord[7:0]),
		.accessBit (insnWord[xid_pkg::ACC_BIT]),
		.bankSel   (bankSel),
		.stackPtr  (ptr2),
		.dataAddr  (mappedAddr)
	);

	// next-value logic for the whole unit
	always_comb begin
		next_state       = xid_pkg::XID_RUN;
		next_ptr0        = ptr0;
		next_ptr1        = ptr1;
		next_ptr2        = ptr2;
		next_pcLoad      = 1'b0;
		next_pcTarget    = pcTarget;
		next_stackPush   = 1'b0;
		next_pushAddr    = pushAddr;
		next_stackPop    = 1'b0;
		next_memWrite    = 1'b0;
		next_memAddr     = memAddr;
		next_memData     = memData;
		next_srcHeld     = srcHeld;
		next_idxDest     = idxDest;
		next_busy        = 1'b0;
		// standard ops see the resolved address every cycle
		next_operandAddr = mappedAddr;
		next_operandToW  = !insnWord[xid_pkg::DST_BIT];
		case (state)
			xid_pkg::XID_RUN: begin
				if (insnValid && extOn) begin
					case (opHi)
						xid_pkg::OP_PTR_ADD, xid_pkg::OP_PTR_SUB: begin
							if (sel == xid_pkg::SEL_STACK_RET) begin
								// stack update plus return, then a nop cycle
								next_ptr2     = aluOut;
								next_pcLoad   = 1'b1;
								next_pcTarget = stackTop;
								next_stackPop = 1'b1;
								next_busy     = 1'b1;
								next_state    = xid_pkg::XID_NOP;
							end else if (sel == 2'h_0) begin
								next_ptr0 = aluOut;
							end else if (sel == 2'h_1) begin
								next_ptr1 = aluOut;
							end else begin
								next_ptr2 = aluOut;
							end
						end
						xid_pkg::OP_PUSH_LIT: begin
							// store at stack pointer, then step it down
							next_memWrite = 1'b1;
							next_memAddr  = ptr2;
							next_memData  = insnWord[7:0];
							next_ptr2     = ptr2 - xid_pkg::ONE_12;
						end
						xid_pkg::OP_MOVE_IDX: begin
							// first word: source from stack plus offset
							next_srcHeld = stackRel(ptr2, ofs7);
							next_idxDest = insnWord[xid_pkg::MV_KIND];
							next_busy    = 1'b1;
							next_state   = xid_pkg::XID_MOVE;
						end
						default: begin
							if (insnWord == xid_pkg::OP_CALL_WORK) begin
								// push return address, jump via W and latches
								next_stackPush = 1'b1;
								next_pushAddr  = progCounter + xid_pkg::PC_STEP;
								next_pcLoad    = 1'b1;
								next_pcTarget  = {pcLatchUpper, pcLatchHigh, workReg};
								next_busy      = 1'b1;
								next_state     = xid_pkg::XID_NOP;
							end
						end
					endcase
				end
			end
			xid_pkg::XID_NOP: begin
				// flushed fetch slot; nothing executes
				next_state = xid_pkg::XID_RUN;
			end
			xid_pkg::XID_MOVE: begin
				// second word: destination, then the data write
				if (insnValid) begin
					next_memWrite = 1'b1;
					next_memAddr  = idxDest ? stackRel(ptr2, ofs7) : insnWord[11:0];
					// the caller must not name PC low or stack-top bytes here
					next_memData  = isIndirect(srcHeld) ? xid_pkg::READ_ZERO : rdData;
					next_state    = xid_pkg::XID_RUN;
				end else begin
					next_busy  = 1'b1;
					next_state = xid_pkg::XID_MOVE;
				end
			end
			default: begin
				next_state = xid_pkg::XID_RUN;
			end
		endcase
	end

	// registers only; outputs come straight from these flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= xid_pkg::XID_RUN;
			ptr0        <= 12'h_000;
			ptr1        <= 12'h_000;
			ptr2        <= 12'h_000;
			pcLoad      <= 1'b0;
			pcTarget    <= 21'h_00_0000;
			stackPush   <= 1'b0;
			pushAddr    <= 21'h_00_0000;
			stackPop    <= 1'b0;
			memWrite    <= 1'b0;
			memAddr     <= 12'h_000;
			memData     <= 8'h_00;
			operandAddr <= 12'h_000;
			operandToW  <= 1'b0;
			busy        <= 1'b0;
			srcHeld     <= 12'h_000;
			idxDest     <= 1'b0;
		end else begin
			state       <= next_state;
			ptr0        <= next_ptr0;
			ptr1        <= next_ptr1;
			ptr2        <= next_ptr2;
			pcLoad      <= next_pcLoad;
			pcTarget    <= next_pcTarget;
			stackPush   <= next_stackPush;
			pushAddr    <= next_pushAddr;
			stackPop    <= next_stackPop;
			memWrite    <= next_memWrite;
			memAddr     <= next_memAddr;
			memData     <= next_memData;
			operandAddr <= next_operandAddr;
			operandToW  <= next_operandToW;
			busy        <= next_busy;
			srcHeld     <= next_srcHeld;
			idxDest     <= next_idxDest;
		end
	end

	// nop cycle follows a return or call by exactly one clock
	a_nop_after_jump: assert property (@(posedge core_clk) disable iff (!reset_n)
		pcLoad |-> busy ##1 !busy)
		else $error("jump not followed by single nop");

	// disabled config never changes any pointer
	a_cfg_gate_ptr: assert property (@(posedge core_clk) disable iff (!reset_n)
		!xinstCfg && state == xid_pkg::XID_RUN |=> $stable(ptr0) && $stable(ptr1) && $stable(ptr2))
		else $error("pointer moved with extension off");

	// push writes the old stack pointer, which then drops by one
	a_push_decrement: assert property (@(posedge core_clk) disable iff (!reset_n)
		xinstCfg && insnValid && state == xid_pkg::XID_RUN && opHi == xid_pkg::OP_PUSH_LIT
		|=> memWrite && memAddr == $past(ptr2) && ptr2 == $past(ptr2) - xid_pkg::ONE_12)
		else $error("push literal wrong");

	// call pushes next address and jumps via W and latches
	a_call_target: assert property (@(posedge core_clk) disable iff (!reset_n)
		xinstCfg && insnValid && state == xid_pkg::XID_RUN && insnWord == xid_pkg::OP_CALL_WORK
		|=> stackPush && pushAddr == $past(progCounter) + xid_pkg::PC_STEP
		&& pcTarget[7:0] == $past(workReg))
		else $error("call target wrong");

	// latches go to the upper bytes of the call target
	a_call_latches: assert property (@(posedge core_clk) disable iff (!reset_n)
		stackPush |-> pcLoad && pcTarget[20:8] == {$past(pcLatchUpper), $past(pcLatchHigh)})
		else $error("call latches wrong");

	// add to pointer 0 takes one cycle and is exact
	a_add_ptr0: assert property (@(posedge core_clk) disable iff (!reset_n)
		xinstCfg && insnValid && state == xid_pkg::XID_RUN && opHi == xid_pkg::OP_PTR_ADD
		&& sel == 2'h_0 |=> ptr0 == $past(ptr0) + {6'h_00, $past(lit6)})
		else $error("pointer add wrong");

	// subtract from pointer 1 takes one cycle and is exact
	a_sub_ptr1: assert property (@(posedge core_clk) disable iff (!reset_n)
		xinstCfg && insnValid && state == xid_pkg::XID_RUN && opHi == xid_pkg::OP_PTR_SUB
		&& sel == 2'h_1 |=> ptr1 == $past(ptr1) - {6'h_00, $past(lit6)})
		else $error("pointer subtract wrong");

	// move write lands two cycles after the first word
	sequence s_move_first;
		xinstCfg && insnValid && state == xid_pkg::XID_RUN && opHi == xid_pkg::OP_MOVE_IDX;
	endsequence
	a_move_two_cycle: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_move_first ##1 insnValid |=> memWrite)
		else $error("indexed move did not write");

	// indirect source reads zero
	a_indirect_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
		state == xid_pkg::XID_MOVE && insnValid && isIndirect(srcHeld)
		|=> memData == xid_pkg::READ_ZERO)
		else $error("indirect source not zero");

	// low access operand resolves stack-relative when enabled
	a_indexed_map: assert property (@(posedge core_clk) disable iff (!reset_n)
		xinstCfg && !insnWord[xid_pkg::ACC_BIT] && insnWord[7:0] <= xid_pkg::IDX_LIMIT
		|=> operandAddr == $past(ptr2) + {4'h_0, $past(insnWord[7:0])})
		else $error("indexed operand address wrong");

	// selector three on add or subtract, taken in the run state
	sequence s_return_word;
		xinstCfg && insnValid && state == xid_pkg::XID_RUN && sel == xid_pkg::SEL_STACK_RET
		&& (opHi == xid_pkg::OP_PTR_ADD || opHi == xid_pkg::OP_PTR_SUB);
	endsequence
	a_return_pop: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_return_word |=> pcLoad && stackPop && busy && pcTarget == $past(stackTop))
		else $error("return did not pop the stack");

	// the flushed slot must not start anything, whatever word is offered
	a_nop_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
		state == xid_pkg::XID_NOP |=> !pcLoad && !stackPush && !stackPop && !memWrite && !busy)
		else $error("nop cycle was not idle");

	// absolute destination comes straight from the second word
	a_move_abs_dest: assert property (@(posedge core_clk) disable iff (!reset_n)
		state == xid_pkg::XID_MOVE && insnValid && !idxDest
		|=> memWrite && memAddr == $past(insnWord[11:0]))
		else $error("absolute move destination wrong");

	// indexed destination is the stack pointer plus the second offset
	a_move_idx_dest: assert property (@(posedge core_clk) disable iff (!reset_n)
		state == xid_pkg::XID_MOVE && insnValid && idxDest
		|=> memWrite && memAddr == $past(ptr2) + {5'h_00, $past(ofs7)})
		else $error("indexed move destination wrong");

	// an ordinary source passes its read value through untouched
	a_move_source: assert property (@(posedge core_clk) disable iff (!reset_n)
		state == xid_pkg::XID_MOVE && insnValid && !isIndirect(srcHeld)
		|=> memData == $past(rdData))
		else $error("move source value wrong");

	// access bit set always selects the banked location
	a_bank_select: assert property (@(posedge core_clk) disable iff (!reset_n)
		insnWord[xid_pkg::ACC_BIT]
		|=> operandAddr == {$past(bankSel), $past(insnWord[7:0])})
		else $error("banked operand address wrong");
endmodule : xid_decode_core

// File: verilog/xid_ptr_alu.sv
// pointer adder: add or subtract a six-bit literal, wraps in the data space
module xid_ptr_alu (
	input  wire logic [11:0] ptrIn,   // selected pointer value
	input  wire logic [5:0]  lit,     // unsigned literal
	input  wire logic        doSub,   // 1 = subtract
	output logic      [11:0] ptrOut   // new pointer value
);
	// modulo 4096 arithmetic; no flag outputs exist at all
	always_comb begin
		if (doSub) begin
			ptrOut = ptrIn - {6'h_00, lit};
		end else begin
			ptrOut = ptrIn + {6'h_00, lit};
		end
	end
endmodule : xid_ptr_alu
